// ==== hdl/sstm_port.sv ====
// Synchronous serial port with tail-mark bus mode
//
// Added by the designer: the register addresses and the strobed register port.
module sstm_port
    import sstm_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_sub_tick,
    input  wire logic       i_serial_clock_pin,
    input  wire logic       i_serial_in_pin,
    output logic [7:0]      o_rdata,
    output logic            o_serial_clock_pin,
    output logic            o_serial_clock_oe,
    output logic            o_serial_out_pin,
    output logic            o_xfer_done_irq_flag
);
    logic        rst_s1_q;
    logic        rst_n_q;
    logic [7:0]  ctl_q;
    logic [7:0]  ckstop_q;
    logic [7:0]  hi_q;
    logic [7:0]  lo_q;
    logic [4:0]  cnt_q;
    logic        start_q;
    logic        ovr_q;
    logic        ext_prev_q;
    sstm_state_t st_q;
    logic        half_tick;
    logic        tail_busy;
    logic        tail_fin;
    logic        tail_sclk;
    logic        tail_sdo;
    logic        sclk_d;
    logic        so_d;
    logic [7:0]  rd_mux;

    // Reset released through two flops, asserted at once
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Bus write decode
    wire wr_ctl  = i_wr && i_addr == REG_CTRL;
    wire wr_sts  = i_wr && i_addr == REG_STATUS;
    wire wr_hi   = i_wr && i_addr == REG_DATA_U;
    wire wr_lo   = i_wr && i_addr == REG_DATA_L;
    wire wr_ckst = i_wr && i_addr == REG_CKSTOP;
    wire wr_irq  = i_wr && i_addr == REG_IRQ;

    // Mode decode from the control, clock stop and state registers
    wire standby   = !ckstop_q[CKS_STBY]; // R1
    wire ext       = ctl_q[CTL_SRC]; // R23
    wire len16     = ctl_q[CTL_MODE_LO]; // R7
    wire tail_en   = ctl_q[CTL_TAIL_EN];
    wire cont_mode = ctl_q[CTL_MODE_HI] && !ctl_q[CTL_MODE_LO]; // R3
    wire idle      = st_q == ST_IDLE;
    wire shifting  = st_q == ST_SHIFT;

    // Control write with tail disabled restarts the engine
    wire init_wr = wr_ctl && !i_wdata[CTL_TAIL_EN]; // R8
    wire kill    = standby || init_wr;
    wire go      = wr_sts && i_wdata[STS_START] && idle && !standby; // R9

    // Serial clock edges from prescaler or from the pin
    wire ext_rise = ext && i_serial_clock_pin && !ext_prev_q;
    wire ext_fall = ext && !i_serial_clock_pin && ext_prev_q;
    wire int_rise = !ext && half_tick && !o_serial_clock_pin;
    wire int_fall = !ext && half_tick && o_serial_clock_pin;
    wire rise_ev  = shifting && (ext ? ext_rise : int_rise); // R12
    wire fall_ev  = shifting && (ext ? ext_fall : int_fall); // R12
    wire last_bit = cnt_q == (len16 ? LAST_BIT_16 : LAST_BIT_8);
    wire word_done = rise_ev && last_bit;

    // External clock edges with no transfer running count as overrun
    wire ovr_hit = ext && idle && (ext_rise || ext_fall); // R13

    // Output level write only honoured while idle, not in tail mode
    wire sol_ok = wr_sts && idle && !tail_en; // R14

    sstm_prescaler #(
        .CNT_W       (PRE_W)
    ) u_pre (
        .i_clk       (i_ref_clk),
        .i_rst_n     (rst_n_q),
        .i_sel       (ctl_q[2:0]),
        .i_sub_tick  (i_sub_tick),
        .o_half_tick (half_tick)
    );

    sstm_tail_gen u_tail (
        .i_clk       (i_ref_clk),
        .i_rst_n     (rst_n_q),
        .i_kill      (kill),
        .i_start     (word_done && tail_en), // R16
        .i_latch     (ctl_q[CTL_LATCH]), // R17
        .i_half_tick (half_tick), // R18
        .o_busy      (tail_busy),
        .o_fin       (tail_fin),
        .o_sclk      (tail_sclk),
        .o_sdo       (tail_sdo)
    );

    // Clock pin: tail pattern during tail; toggles during shift or continuous mode on internal clock, else high
    always_comb
    begin
        if (kill)
            sclk_d = 1'b1;
        else if (tail_busy)
            sclk_d = tail_sclk; // R26
        else if ((shifting || cont_mode) && !ext) // R11
            sclk_d = half_tick ? !o_serial_clock_pin : o_serial_clock_pin;
        else
            sclk_d = 1'b1;
    end

    // Data pin: new bit on falling edge, last bit held after
    always_comb
    begin
        if (standby)
            so_d = 1'b0; // R1
        else if (tail_busy)
            so_d = tail_sdo; // R16
        else if (fall_ev)
            so_d = lo_q[0]; // R4
        else if (sol_ok)
            so_d = i_wdata[STS_SOL]; // R14
        else
            so_d = o_serial_out_pin; // R11
    end

    // Pin registers, so every pin comes straight from a flop
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_serial_clock_pin <= 1'b1;
            o_serial_out_pin   <= 1'b0;
            o_serial_clock_oe  <= 1'b0;
            ext_prev_q         <= 1'b1;
        end
        else
        begin
            o_serial_clock_pin <= sclk_d;
            o_serial_out_pin   <= so_d;
            o_serial_clock_oe  <= !ext && !standby; // R23
            ext_prev_q         <= i_serial_clock_pin;
        end
    end

    // Control and clock stop registers
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctl_q    <= CTL_RESET;
            ckstop_q <= CKS_RESET;
        end
        else
        begin
            if (wr_ckst)
                ckstop_q <= i_wdata;
            if (standby)
                ctl_q <= CTL_RESET; // R1
            else if (wr_ctl)
                ctl_q <= i_wdata;
        end
    end

    // Transfer state: shift, then tail when bus mode is on
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            st_q <= ST_IDLE;
        else if (kill)
            st_q <= ST_IDLE;
        else
        begin
            unique case (st_q)
                ST_IDLE:
                    if (go)
                        st_q <= ST_SHIFT;
                ST_SHIFT:
                    if (word_done)
                        st_q <= tail_en ? ST_TAIL : ST_IDLE; // R19
                ST_TAIL:
                    if (tail_fin)
                        st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // Start flag: set by a write of one, cleared at word end
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            start_q <= 1'b0;
        else if (kill || word_done)
            start_q <= 1'b0; // R25
        else if (go)
            start_q <= 1'b1; // R9
    end

    // Bit counter counts sampled bits
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            cnt_q <= 5'h00;
        else if (kill || go)
            cnt_q <= 5'h00;
        else if (rise_ev)
            cnt_q <= cnt_q + 5'h01;
    end

    // Shift right: input enters at the top, output leaves bit 0
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end
        else if (standby)
        begin
            hi_q <= 8'h00; // R1
            lo_q <= 8'h00;
        end
        else if (rise_ev && len16)
            {hi_q, lo_q} <= {i_serial_in_pin, hi_q, lo_q[7:1]}; // R6 R15
        else if (rise_ev)
            lo_q <= {i_serial_in_pin, lo_q[7:1]}; // R5 R6
        else if (idle)
        begin
            if (wr_hi)
                hi_q <= i_wdata;
            if (wr_lo)
                lo_q <= i_wdata;
        end
    end

    // Overrun and done flags: a set beats a same-cycle clear
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ovr_q                <= 1'b0;
            o_xfer_done_irq_flag <= 1'b0;
        end
        else
        begin
            if (ovr_hit)
                ovr_q <= 1'b1; // R12
            else if (standby || (wr_sts && !i_wdata[STS_OVR]))
                ovr_q <= 1'b0;
            if (word_done)
                o_xfer_done_irq_flag <= 1'b1; // R10
            else if (wr_irq && !i_wdata[IRQ_DONE])
                o_xfer_done_irq_flag <= 1'b0;
        end
    end

    // Read selection; unmapped addresses read zero
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (i_addr)
            REG_CTRL:   rd_mux = ctl_q;
            REG_STATUS:
            begin
                rd_mux = STS_FIXED;
                rd_mux[STS_SOL]   = o_serial_out_pin;
                rd_mux[STS_OVR]   = ovr_q;
                rd_mux[STS_TAIL]  = st_q == ST_TAIL; // R20
                rd_mux[STS_START] = start_q; // R25
            end
            REG_DATA_U: rd_mux = hi_q;
            REG_DATA_L: rd_mux = lo_q;
            REG_CKSTOP: rd_mux = ckstop_q;
            REG_IRQ:    rd_mux = {7'h00, o_xfer_done_irq_flag};
            default:    rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_rdata <= 8'h00;
        else
            o_rdata <= i_rd ? rd_mux : 8'h00;
    end

    // Checks on the transfer engine
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n_q);

    a_start_clear: assert property (word_done |=> !start_q) // R19
        else $error("start flag not cleared at word end");
    a_done_set: assert property (word_done |=> o_xfer_done_irq_flag) // R10
        else $error("done flag not set at word end");
    a_tail_hold: assert property ( // R20
        (word_done && tail_en && !kill) |=> (st_q == ST_TAIL) [*8])
        else $error("tail flag dropped early");
    a_ovr_ext: assert property ($rose(ovr_q) |-> $past(ext)) // R13
        else $error("overrun set with internal clock");
    a_ovr_frozen: assert property ( // R12
        (ovr_hit && !wr_hi && !wr_lo && !standby)
        |=> $stable(lo_q) && $stable(hi_q))
        else $error("data moved on overrun edge");
    a_lsb_out: assert property ( // R4
        (fall_ev && !kill) |=> o_serial_out_pin == $past(lo_q[0]))
        else $error("wrong bit driven on falling edge");
    a_sample_in: assert property ( // R5
        (rise_ev && !len16 && !standby)
        |=> lo_q[7] == $past(i_serial_in_pin))
        else $error("input bit not sampled on rising edge");
    a_clk_quiet: assert property ( // R11
        (idle && !cont_mode && !tail_busy) ##1 (idle && !cont_mode)
        |-> o_serial_clock_pin)
        else $error("clock toggled while idle");
    a_standby_rst: assert property (standby |=> ctl_q == CTL_RESET) // R1
        else $error("control not reset in standby");
    a_init_wr: assert property (init_wr |=> idle && !start_q) // R8
        else $error("control write did not reinitialize");

    c_word_int: cover property (word_done && !ext);
    c_word_ext: cover property (word_done && ext);
    c_tail_done: cover property (tail_fin && ctl_q[CTL_LATCH]);
    c_overrun: cover property ($rose(ovr_q));
endmodule // sstm_port

// ==== hdl/sstm_pkg.sv ====
// Constants and types shared by the tail-mark serial port
// Notes on behaviour
// (R1) Standby bit low resets control, status, data
// (R2) Eight prescaler clocks or external clock source
// (R3) Mode 10 drives prescaler clock continuously
// (R4) LSB first, output changes on falling edge
// (R5) Receive bit sampled on rising edge
// (R6) 8-bit uses low reg, 16-bit both
// (R7) Software picks plain mode and word length
// (R8) Control write with tail disabled reinitializes
// (R9) Writing start flag one begins transfer
// (R10) Completion sets transfer-done request flag
// (R11) Internal clock only during data, hold bit
// (R12) Late external edges set overrun, move nothing
// (R13) Overrun detected only with external clock
// (R14) Idle output level set by software bit
// (R15) One start both shifts out and in
// (R16) Tail mark follows each word in bus mode
// (R17) Latch-select bit picks hold or latch
// (R18) Tail timing unit is selected clock period
// (R19) After word: start clears, done sets, tail
// (R20) Tail-in-progress flag high during tail
// (R21) Software uses internal clock, period 2 us+
// (R22) Software idles port before changing tail enable
// (R23) Source bit zero internal output, one input
// (R24) Codes select 1024..4 divides, subclock/4
// (R25) Start reads one while busy, write zero ignored
// (R26) Hold and latch tails are distinct patterns
package sstm_pkg;

    // Register indices on the plain port
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_DATA_U = 3'h2;
    localparam logic [2:0] REG_DATA_L = 3'h3;
    localparam logic [2:0] REG_CKSTOP = 3'h4;
    localparam logic [2:0] REG_IRQ    = 3'h5;

    // Control register fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_TAIL_EN = 5;
    localparam int CTL_LATCH   = 4;
    localparam int CTL_SRC     = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Status register fields and fixed bits
    localparam int STS_SOL   = 6;
    localparam int STS_OVR   = 5;
    localparam int STS_TAIL  = 1;
    localparam int STS_START = 0;
    localparam logic [7:0] STS_FIXED = 8'h9C;

    // Module clock stop register and interrupt register done bit
    localparam int CKS_STBY = 7;
    localparam logic [7:0] CKS_RESET = 8'hFF;
    localparam int IRQ_DONE = 0;

    // Index of last bit in each word length
    localparam logic [4:0] LAST_BIT_8  = 5'h07;
    localparam logic [4:0] LAST_BIT_16 = 5'h0F;

    // log2 of prescaler divide for codes 000 to 110
    localparam int DIV_LOG2 [7] = '{10, 8, 6, 5, 4, 3, 2};
    localparam int PRE_W = 10;

    // Tail waveforms: bit n is level in unit step n
    localparam logic [3:0] HOLD_SCLK  = 4'hE;
    localparam logic [3:0] HOLD_SDO   = 4'hC;
    localparam logic [3:0] LATCH_SCLK = 4'hA;
    localparam logic [3:0] LATCH_SDO  = 4'h8;
    localparam logic [2:0] TAIL_LAST  = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_TAIL  = 3'b100
    } sstm_state_t;

endpackage

// ==== hdl/sstm_prescaler.sv ====
// Prescaler giving half-period ticks of the chosen serial clock
module sstm_prescaler
    import sstm_pkg::*;
#(
    parameter int CNT_W = PRE_W
)(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_sel,
    input  wire logic       i_sub_tick,
    output logic            o_half_tick
);
    logic [CNT_W-1:0] cnt_q;
    logic             sub_q;
    logic [7:0]       hit;

    if (CNT_W < PRE_W)
    begin : g_chk
        $error("prescaler counter too narrow");
    end

    // Half period of divide 2^k ends when low k-1 bits are all ones
    for (genvar i = 0; i < 7; i++)
    begin : g_tap
        assign hit[i] = &cnt_q[DIV_LOG2[i]-2:0]; // R24
    end
    // Subclock divided by four: half period is two subclock ticks
    assign hit[7] = i_sub_tick & sub_q; // R24

    // Free-running counters keep phase across transfers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_q       <= '0;
            sub_q       <= 1'b0;
            o_half_tick <= 1'b0;
        end
        else
        begin
            cnt_q       <= cnt_q + CNT_W'(1);
            sub_q       <= sub_q ^ i_sub_tick;
            o_half_tick <= hit[i_sel]; // R2
        end
    end
endmodule // sstm_prescaler

// ==== hdl/sstm_tail_gen.sv ====
// Tail mark waveform generator, stepped by serial half ticks
module sstm_tail_gen
    import sstm_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_kill,
    input  wire logic i_start,
    input  wire logic i_latch,
    input  wire logic i_half_tick,
    output logic      o_busy,
    output logic      o_fin,
    output logic      o_sclk,
    output logic      o_sdo
);
    logic [2:0] step_q;
    logic       latch_q;
    wire  [1:0] unit = step_q[2:1];

    // Each unit spans two half ticks, one full serial period
    assign o_sclk = latch_q ? LATCH_SCLK[unit] : HOLD_SCLK[unit]; // R26
    assign o_sdo  = latch_q ? LATCH_SDO[unit] : HOLD_SDO[unit]; // R26

    // Step counter runs from start until eight half ticks pass
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            step_q  <= 3'h0;
            latch_q <= 1'b0;
            o_busy  <= 1'b0;
            o_fin   <= 1'b0;
        end
        else
        begin
            o_fin <= 1'b0;
            if (i_kill)
                o_busy <= 1'b0;
            else if (i_start)
            begin
                o_busy  <= 1'b1;
                step_q  <= 3'h0;
                latch_q <= i_latch; // R17
            end
            else if (o_busy && i_half_tick) // R18
            begin
                step_q <= step_q + 3'h1;
                if (step_q == TAIL_LAST)
                begin
                    o_busy <= 1'b0;
                    o_fin  <= 1'b1;
                end
            end
        end
    end
endmodule // sstm_tail_gen

// ==== dv/sstm_peer.sv ====
// Far-side model: serial peripheral chip and external clock master
module sstm_peer
(
    input  wire logic i_clk,
    input  wire logic i_line,
    input  wire logic i_sdo,
    output logic      o_sin,
    output logic      o_ext_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] tx_q = 16'h0000;
    logic [15:0] rx_q = 16'h0000;
    int          cnt_q = 0;
    int          nbits_q = 0;
    logic        prev_q = 1'b1;

    initial
    begin
        o_ext_clk = 1'b1;
        o_sin = 1'b0;
    end

    // Load a frame; the clocked process presents bit 0 on the next edge
    task automatic arm(input int n, input logic [15:0] tx);
        nbits_q = n;
        cnt_q = 0;
        tx_q = tx;
    endtask

    // Capture on rising edges, move data on falling edges; outside a
    // frame the input line toggles so no stale bit can pass as data
    always @(posedge i_clk)
    begin
        prev_q <= i_line;
        if (cnt_q >= nbits_q)
            o_sin <= ~o_sin;
        else if (i_line && !prev_q)
        begin
            rx_q <= {i_sdo, rx_q[15:1]};
            cnt_q <= cnt_q + 1;
        end
        else if (!i_line && prev_q)
            o_sin <= tx_q[cnt_q];
        else if (cnt_q == 0)
            o_sin <= tx_q[0];
    end

    // External clock periods; the line idles high between bursts
    task automatic pulses(input int n, input int h);
        repeat (n)
        begin
            repeat (h) @(posedge i_clk);
            o_ext_clk <= 1'b0;
            repeat (h) @(posedge i_clk);
            o_ext_clk <= 1'b1;
        end
    endtask
endmodule // sstm_peer

// ==== dv/sync_serial_tail_mark_port_bench.sv ====
// Self-checking bench for the tail-mark serial port
module sync_serial_tail_mark_port_bench
    import sstm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sub = 1'b0;
    int          sc = 0;
    wire logic   sin;
    wire logic   ext_clk;
    wire logic   line;
    wire logic   sck_o;
    wire logic   sck_oe;
    wire logic   sdo;
    wire logic   irq;
    wire logic [7:0] rdata;
    int          err_count = 0;
    int          tests_run = 0;
    int          rises = 0;
    logic [31:0] seed = 32'hBF6BDBFE;
    int          divs [8] = '{1024, 256, 64, 32, 16, 8, 4, 32};

    // 200 MHz clock; subclock pulse every 8 cycles
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        sc <= (sc + 1) % 8;
        sub <= (sc == 0);
    end

    // Rising edges on the clock pin, used to tell tail types apart
    always @(posedge sck_o)
        rises <= rises + 1;

    // Clock wire: device drives it when enabled, else the peer
    assign line = sck_oe ? sck_o : ext_clk;

    sstm_port dut_u (
        .i_ref_clk           (clk),
        .i_reset_n           (rst_n),
        .i_addr              (addr),
        .i_wdata             (wdata),
        .i_wr                (wr),
        .i_rd                (rd),
        .i_sub_tick          (sub),
        .i_serial_clock_pin  (line),
        .i_serial_in_pin     (sin),
        .o_rdata             (rdata),
        .o_serial_clock_pin  (sck_o),
        .o_serial_clock_oe   (sck_oe),
        .o_serial_out_pin    (sdo),
        .o_xfer_done_irq_flag(irq)
    );

    sstm_peer peer_u (
        .i_clk    (clk),
        .i_line   (line),
        .i_sdo    (sdo),
        .o_sin    (sin),
        .o_ext_clk(ext_clk)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Bus cycles; each ends one edge after its strobe drops
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic expect_reg(input logic [2:0] a, input logic [7:0] e,
                              input logic [7:0] m);
        logic [7:0] d;
        rd_reg(a, d);
        check({8'h00, d & m}, {8'h00, e & m}, "register");
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        check(irq, 1'b1, "done flag");
    endtask

    // One full-duplex word against the peer's model of the line
    task automatic xfer(input logic [7:0] ctl);
        logic [15:0] tx;
        logic [15:0] rx;
        logic [15:0] msk;
        int          nb;
        nb = ctl[CTL_MODE_LO] ? 16 : 8;
        msk = ctl[CTL_MODE_LO] ? 16'hFFFF : 16'h00FF;
        seed = lfsr(seed);
        tx = seed[15:0];
        seed = lfsr(seed);
        rx = seed[31:16];
        wr_reg(REG_CTRL, ctl);
        wr_reg(REG_DATA_L, tx[7:0]);
        // Enable flop follows the control write one edge later
        check(sck_oe, !ctl[CTL_SRC], "clock enable");
        wr_reg(REG_DATA_U, tx[15:8]);
        peer_u.arm(nb, rx);
        wr_reg(REG_STATUS, 8'h01);
        expect_reg(REG_STATUS, 8'h9D, 8'hBF);
        if (ctl[CTL_SRC])
            peer_u.pulses(nb, 6);
        wait_irq(2000);
        // On internal clock the peer sees the last clock rise one edge after the device
        @(posedge clk);
        check((peer_u.rx_q >> (16 - nb)), tx & msk, "sent");
        check(sdo, tx[nb-1], "last bit");
        check(line, 1'b1, "clock idle");
        expect_reg(REG_DATA_L, rx[7:0], 8'hFF);
        expect_reg(REG_DATA_U, nb == 16 ? rx[15:8] : tx[15:8], 8'hFF);
        expect_reg(REG_STATUS, {1'b1, tx[nb-1], 6'h1C}, 8'hFF);
        expect_reg(REG_IRQ, 8'h01, 8'hFF);
        if (ctl[CTL_SRC])
        begin
            peer_u.pulses(2, 6);
            expect_reg(REG_STATUS, 8'hBC, 8'hBF);
            expect_reg(REG_DATA_L, rx[7:0], 8'hFF);
            wr_reg(REG_STATUS, 8'h00);
            expect_reg(REG_STATUS, 8'h9C, 8'hFF);
        end
        wr_reg(REG_IRQ, 8'h00);
        check(irq, 1'b0, "done clear");
    endtask

    task automatic results();
        $display("Compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clk);
        $display("FAIL %0t watchdog", $time);
        err_count++;
        results();
    end

    // Main sequence
    initial
    begin
        int          i;
        int          n;
        int          r0;
        logic [7:0]  d;
        realtime     t0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        expect_reg(REG_CTRL, CTL_RESET, 8'hFF);
        expect_reg(REG_STATUS, 8'h9C, 8'hFF);
        expect_reg(REG_CKSTOP, 8'hFF, 8'hFF);
        wr_reg(3'h7, 8'h5A);
        expect_reg(3'h7, 8'h00, 8'hFF);
        wr_reg(REG_STATUS, 8'h00);
        expect_reg(REG_STATUS, 8'h9C, 8'hFF);
        wr_reg(REG_STATUS, 8'h40);
        check(sdo, 1'b1, "level");
        expect_reg(REG_STATUS, 8'hDC, 8'hFF);
        // Standby clears registers and refuses a start
        wr_reg(REG_DATA_L, 8'h5A);
        wr_reg(REG_CTRL, 8'h45);
        wr_reg(REG_CKSTOP, 8'h7F);
        expect_reg(REG_CTRL, 8'h00, 8'hFF);
        expect_reg(REG_DATA_L, 8'h00, 8'hFF);
        wr_reg(REG_STATUS, 8'h01);
        expect_reg(REG_STATUS, 8'h9C, 8'hFF);
        wr_reg(REG_CKSTOP, 8'hFF);
        // Transfers: internal divide 16 and 32, then external clock
        for (i = 0; i < 6; i++)
            xfer(8'((i % 2) * 64 + (i < 2 ? 4 : i < 4 ? 3 : 8)));
        // Control write mid-transfer aborts the word
        wr_reg(REG_CTRL, 8'h03);
        peer_u.arm(8, 16'h00A5);
        wr_reg(REG_STATUS, 8'h01);
        repeat (100) @(posedge clk);
        wr_reg(REG_CTRL, 8'h03);
        expect_reg(REG_STATUS, 8'h9C, 8'hBF);
        repeat (800) @(posedge clk);
        check(irq, 1'b0, "aborted");
        // Continuous clock: period of every divide code
        for (i = 0; i < 8; i++)
        begin
            wr_reg(REG_CTRL, 8'(128 + i));
            @(posedge sck_o);
            t0 = $realtime;
            @(posedge sck_o);
            check(16'(int'(($realtime - t0) / 5.0)), 16'(divs[i]),
                  "period");
            @(posedge clk);
        end
        // Tail-mark mode, hold then latch type; slowest divide keeps
        // the serial period above two microseconds
        for (i = 0; i < 2; i++)
        begin
            seed = lfsr(seed);
            wr_reg(REG_CTRL, 8'(32 + 16 * i));
            wr_reg(REG_DATA_L, seed[7:0]);
            peer_u.arm(8, seed[31:16]);
            wr_reg(REG_STATUS, 8'h01);
            n = 0;
            d = 8'h00;
            while (d[STS_TAIL] !== 1'b1 && n < 6000)
            begin
                rd_reg(REG_STATUS, d);
                n++;
            end
            check(d[STS_TAIL], 1'b1, "tail flag");
            check(d[STS_START], 1'b0, "start cleared");
            check(irq, 1'b1, "done at tail");
            check(peer_u.rx_q[15:8], seed[7:0], "tail word");
            r0 = rises;
            while (d[STS_TAIL] === 1'b1 && n < 9000)
            begin
                rd_reg(REG_STATUS, d);
                n++;
            end
            check(d & 8'hBF, 8'h9C, "tail end");
            // Hold tail clock is low then high; latch pulses twice
            check(16'(rises - r0), 16'(i + 1), "tail rises");
            check(line, 1'b1, "clock idle");
            wr_reg(REG_IRQ, 8'h00);
        end
        wr_reg(REG_CTRL, 8'h00);
        results();
    end
endmodule // sync_serial_tail_mark_port_bench
